//--- core/amtt_top.sv
// How it works
// - Mask gates alert only, flags still set
// - Mask one bit 7 gates second bank
// - Mask one bits 6..0 gate first sources
// - Mask two bits 7,6 gate diode faults
// - Mask two bit 5 gates fourth source
// - Mask two bits 4..0 gate fans, overheat, rail
// - Alert output enabled after reset, masks clear
// - Config three bit routes alert to duty pin
// - Config four bits 1:0 pick pin function
// - Throttle enable selects throttle or measurement
// - Full_speed_on_throttle forces full duty while throttle low
// - Full_speed_on_throttle applies only to running fans
// - Timer runs while asserted, pauses, resumes
// - Timer saturates at full scale until read
// - Timer bit 0 set on first assertion
// - After two units timer counts unit steps
// - Timer read clears timer
// - Read during assertion restarts from one
// - Zero limit re-sets fourth flag on read
// - Alert held while out of limit, until read
// - Flags sticky, read clears only gone conditions
`default_nettype none
module amtt_top
  import amtt_pkg::*;
#(
  parameter int UNIT_CYCLES = amtt_pkg::TIMER_UNIT_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output var  logic [7:0] reg_rdata,
  input  wire logic [6:0] cond_first,
  input  wire logic [7:0] cond_second,
  input  wire logic       thermal_throttle_line_n,
  input  wire logic       multi_pin_in,
  input  wire logic       second_duty_output,
  input  wire logic [3:0] fan_running,
  output var  logic [3:0] fan_full_duty,
  output var  logic       duty_pin_out,
  output var  logic       duty_pin_oe,
  output var  logic       multi_pin_out,
  output var  logic       multi_pin_oe,
  output var  logic       alert_n
);
  import amtt_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic       throttle_pin_s;
  logic       multi_pin_s;
  logic [1:0] pins_s;

  amtt_sync #(.WIDTH(2), .INIT(2'b11)) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({thermal_throttle_line_n, multi_pin_in}),
    .sync_out (pins_s)
  );
  assign throttle_pin_s = pins_s[1];
  assign multi_pin_s    = pins_s[0];

  // ---------------------------------------------------------------
  // Configuration and mask registers
  // ---------------------------------------------------------------
  logic [7:0]     alert_mask_first_reg;
  logic [7:0]     alert_mask_second_reg;
  logic [7:0]     config_three_reg;
  logic [7:0]     timer_limit_reg;
  amtt_pin_func_t pin_func_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_mask_first_reg  <= RST_MASK;
      alert_mask_second_reg <= RST_MASK;
      config_three_reg      <= RST_CONFIG;
      timer_limit_reg       <= RST_LIMIT;
      pin_func_reg          <= PIN_SPEED_SENSE;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_MASK_FIRST:   alert_mask_first_reg  <= reg_wdata;
        ADDR_MASK_SECOND:  alert_mask_second_reg <= reg_wdata;
        ADDR_CONFIG_THREE: config_three_reg      <= reg_wdata;
        ADDR_TIMER_LIMIT:  timer_limit_reg       <= reg_wdata;
        ADDR_CONFIG_FOUR:  pin_func_reg          <= amtt_pin_func_t'(reg_wdata[1:0]);
        default: begin
        end
      endcase
    end
  end

  logic throttle_en;
  logic full_speed_on_throttle_en;
  logic alert_on_duty;
  logic multi_is_throttle;
  logic throttle_active;

  assign throttle_en   = config_three_reg[BIT_THROTTLE_EN];
  assign full_speed_on_throttle_en      = config_three_reg[BIT_FULL_SPEED_ON_THROTTLE];
  assign alert_on_duty = config_three_reg[BIT_ALERT_ON_DUTY];
  // Without the enable the dedicated pin is a measurement input.
  assign multi_is_throttle = throttle_en && (pin_func_reg == PIN_THROTTLE);
  assign throttle_active   = (throttle_en && !throttle_pin_s) ||
                             (multi_is_throttle && !multi_pin_s);

  // ---------------------------------------------------------------
  // Throttle timer
  // ---------------------------------------------------------------
  logic       timer_rd;
  logic       unit_tick;
  logic       seen_reg;
  logic [7:0] units_reg;
  logic [7:0] timer_value;

  assign timer_rd = reg_rd && (reg_addr == ADDR_TIMER);

  amtt_tick #(.DIVIDE(UNIT_CYCLES)) u_tick (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .run     (throttle_active),
    .restart (timer_rd),
    .tick    (unit_tick)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_reg  <= 1'b0;
      units_reg <= 8'h00;
    end else if (timer_rd) begin
      seen_reg  <= throttle_active;
      units_reg <= 8'h00;
    end else begin
      if (throttle_active) begin
        seen_reg <= 1'b1;
      end
      if (unit_tick && throttle_active && units_reg != TIMER_FULL) begin
        units_reg <= units_reg + 8'h01;
      end
    end
  end

  // The first unit shows as 1 already, so the value only moves on at two units.
  assign timer_value = (units_reg == 8'h00) ? {7'h00, seen_reg} : units_reg;

  logic timer_over;
  assign timer_over = timer_value > timer_limit_reg;

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  logic [7:0] status_first_reg;
  logic [7:0] status_second_reg;
  logic [6:0] first_cause;
  logic [7:0] second_cause;
  logic       fourth_cause;

  always_comb begin
    case (pin_func_reg)
      PIN_SPEED_SENSE: fourth_cause = cond_second[BIT_FOURTH_SRC2];
      PIN_THROTTLE:    fourth_cause = multi_is_throttle && timer_over;
      PIN_SPARE_IO:    fourth_cause = !multi_pin_s;
      default:         fourth_cause = 1'b0;
    endcase
  end

  always_comb begin
    first_cause = cond_first;
    if (throttle_en) begin
      first_cause[BIT_THROTTLE_SRC1] = timer_over;
    end
    second_cause = cond_second;
    second_cause[BIT_FOURTH_SRC2] = fourth_cause;
  end

  function automatic logic [7:0] sticky_next(input logic [7:0] flags,
                                             input logic [7:0] cause,
                                             input logic       rd);
    // A new cause wins over a read in the same cycle.
    sticky_next = (rd ? (flags & cause) : flags) | cause;
  endfunction

  logic rd_first;
  logic rd_second;
  assign rd_first  = reg_rd && (reg_addr == ADDR_STATUS_FIRST);
  assign rd_second = reg_rd && (reg_addr == ADDR_STATUS_SECOND);

  logic [7:0] first_next;
  logic [7:0] second_next;
  assign first_next  = sticky_next({1'b0, status_first_reg[6:0]},
                                   {1'b0, first_cause}, rd_first);
  assign second_next = sticky_next(status_second_reg, second_cause, rd_second);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_first_reg  <= 8'h00;
      status_second_reg <= 8'h00;
    end else begin
      // The summary bit tracks the second bank, so a read of the first never clears it.
      status_first_reg  <= {|second_next, first_next[6:0]};
      status_second_reg <= second_next;
    end
  end

  // ---------------------------------------------------------------
  // Alert combination
  // ---------------------------------------------------------------
  logic alert_first;
  logic alert_second;
  logic alert_any;

  assign alert_first  = |(status_first_reg[6:0] & ~alert_mask_first_reg[6:0]);
  assign alert_second = |(status_second_reg & ~alert_mask_second_reg) &&
                        !alert_mask_first_reg[BIT_SUMMARY];
  assign alert_any    = alert_first || alert_second;

  // ---------------------------------------------------------------
  // Pin drivers and fan full_speed_on_throttle
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_n       <= 1'b1;
      duty_pin_out  <= 1'b0;
      duty_pin_oe   <= 1'b0;
      multi_pin_out <= 1'b0;
      multi_pin_oe  <= 1'b0;
      fan_full_duty <= 4'h0;
    end else begin
      alert_n <= !alert_any;
      if (alert_on_duty) begin
        duty_pin_out <= 1'b0;
        duty_pin_oe  <= alert_any;
      end else begin
        duty_pin_out <= second_duty_output;
        duty_pin_oe  <= 1'b1;
      end
      multi_pin_out <= 1'b0;
      multi_pin_oe  <= (pin_func_reg == PIN_ALERT) && alert_any;
      fan_full_duty <= (full_speed_on_throttle_en && throttle_active) ? fan_running : 4'h0;
    end
  end

  // ---------------------------------------------------------------
  // Register read data
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_STATUS_FIRST:  reg_rdata <= status_first_reg;
        ADDR_STATUS_SECOND: reg_rdata <= status_second_reg;
        ADDR_MASK_FIRST:    reg_rdata <= alert_mask_first_reg;
        ADDR_MASK_SECOND:   reg_rdata <= alert_mask_second_reg;
        ADDR_CONFIG_THREE:  reg_rdata <= config_three_reg;
        ADDR_TIMER:         reg_rdata <= timer_value;
        ADDR_TIMER_LIMIT:   reg_rdata <= timer_limit_reg;
        ADDR_CONFIG_FOUR:   reg_rdata <= {6'h00, pin_func_reg};
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_read_while_on;
    timer_rd && throttle_active;
  endsequence

  sequence s_restart_at_one;
    ##1 (timer_value == 8'h01);
  endsequence

  a_alert_follows_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 (alert_n == !$past(alert_any)))
    else $error("alert output does not follow unmasked flags");

  a_mask_keeps_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (second_cause[7] && alert_mask_second_reg[7]) |=> status_second_reg[7])
    else $error("masked source did not set its flag");

  a_summary_gates_second: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (alert_mask_first_reg[BIT_SUMMARY] && status_first_reg[6:0] == 7'h00) |-> !alert_any)
    else $error("summary mask failed to gate second bank");

  a_read_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_read_while_on |-> s_restart_at_one)
    else $error("timer not restarted at one on read during assertion");

  a_read_clears_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (timer_rd && !throttle_active) |=> (timer_value == 8'h00))
    else $error("timer not cleared by read");

  a_timer_paused: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!throttle_active && !timer_rd) |=> $stable(timer_value))
    else $error("timer moved while throttle released");

  a_timer_saturates: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (units_reg == TIMER_FULL && !timer_rd) |=> (units_reg == TIMER_FULL))
    else $error("timer left full scale without read");

  a_sticky_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (status_second_reg[0] && !rd_second) |=> status_second_reg[0])
    else $error("status flag dropped without read");

  a_full_speed_on_throttle_needs_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (full_speed_on_throttle_en && throttle_active && fan_running[0]) |=> fan_full_duty[0])
    else $error("full_speed_on_throttle not applied to running fan");

  a_alert_pin_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pin_func_reg != PIN_ALERT) |=> !multi_pin_oe)
    else $error("multi pin driven outside alert function");

  a_duty_pin_routed: assert property (@(posedge ref_clk) disable iff (!rst_n)
    alert_on_duty |=> ((duty_pin_oe == $past(alert_any)) && !duty_pin_out))
    else $error("duty pin does not carry the alert");

  a_seen_shows_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (throttle_active && !timer_rd) |=> (timer_value != 8'h00))
    else $error("timer reads zero after a throttle assertion");

  a_unit_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (unit_tick && !timer_rd && units_reg != TIMER_FULL) |=>
    (units_reg == $past(units_reg) + 8'h01))
    else $error("timer did not step by one unit");

  a_idle_fan_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !fan_running[0] |=> !fan_full_duty[0])
    else $error("full_speed_on_throttle applied to a stopped fan");

  a_throttle_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!throttle_en && !timer_rd) |=> $stable(timer_value))
    else $error("timer moved with throttle function disabled");

  a_zero_limit_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_read_while_on ##0 (multi_is_throttle && timer_limit_reg == 8'h00)) |->
    ##2 status_second_reg[BIT_FOURTH_SRC2])
    else $error("zero limit did not set the fourth flag on read");
endmodule
`default_nettype wire

//--- inc/amtt_pkg.sv
`default_nettype none
package amtt_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS_FIRST  = 8'h41;
  localparam logic [7:0] ADDR_STATUS_SECOND = 8'h42;
  localparam logic [7:0] ADDR_MASK_FIRST    = 8'h74;
  localparam logic [7:0] ADDR_MASK_SECOND   = 8'h75;
  localparam logic [7:0] ADDR_CONFIG_THREE  = 8'h78;
  localparam logic [7:0] ADDR_TIMER         = 8'h79;
  localparam logic [7:0] ADDR_TIMER_LIMIT   = 8'h7A;
  localparam logic [7:0] ADDR_CONFIG_FOUR   = 8'h7D;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_SUMMARY       = 7;
  localparam int BIT_THROTTLE_SRC1 = 0;
  localparam int BIT_FOURTH_SRC2   = 5;
  localparam int BIT_ALERT_ON_DUTY = 0;
  localparam int BIT_THROTTLE_EN   = 1;
  localparam int BIT_FULL_SPEED_ON_THROTTLE         = 2;

  // ---------------------------------------------------------------
  // Reset values and timer full scale
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MASK   = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_LIMIT  = 8'h00;
  localparam logic [7:0] TIMER_FULL = 8'hFF;

  // ---------------------------------------------------------------
  // Multi-function pin selection
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PIN_SPEED_SENSE = 2'b00,
    PIN_THROTTLE    = 2'b01,
    PIN_ALERT       = 2'b10,
    PIN_SPARE_IO    = 2'b11
  } amtt_pin_func_t;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIMER_UNIT_NS = 22_760_000;
  localparam int TIMER_UNIT_CYCLES = TIMER_UNIT_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

//--- core/amtt_sync.sv
`default_nettype none
module amtt_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= INIT;
      sync_out  <= INIT;
    end else begin
      stage_reg <= async_in;
      sync_out  <= stage_reg;
    end
  end
endmodule
`default_nettype wire

//--- core/amtt_tick.sv
`default_nettype none
module amtt_tick #(
  parameter int DIVIDE = 227600
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic restart,
  output var  logic tick
);
  localparam int CW = $clog2(DIVIDE + 1);
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

  logic [CW-1:0] count_reg;

  // The tick comes out in the cycle of the last count, so a unit that completes
  // on the final active cycle is not lost when the line releases.
  assign tick = run && !restart && (count_reg == LAST);

  // The count holds while stopped so that partial units carry over.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (restart) begin
      count_reg <= '0;
    end else if (run) begin
      count_reg <= (count_reg == LAST) ? '0 : count_reg + CW'(1);
    end
  end
endmodule
`default_nettype wire

//--- dv/amtt_hot_source.sv
`default_nettype none
module amtt_hot_source (
  input  wire logic hot_req,
  output wire logic line_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // The line is pulled up on the board, so releasing it reads high, never a held value.
  assign line_n = hot_req ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

//--- dv/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import amtt_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int UNIT = 8;
  localparam logic [47:0] RST_ADDRS = 48'h7475_787A_7D50;
  logic       ref_clk;
  logic       rst_n;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [6:0] cond_first;
  logic [7:0] cond_second;
  logic       hot_a;
  logic       hot_b;
  wire        throttle_n;
  wire        multi_n;
  logic       second_duty_output;
  logic [3:0] fan_running;
  logic [3:0] fan_full_duty;
  logic       duty_pin_out;
  logic       duty_pin_oe;
  logic       multi_pin_out;
  logic       multi_pin_oe;
  logic       alert_n;
  int         errors;
  int         samples_checked;
  int         cycles;
  int         seed = 48785;

  amtt_top #(.UNIT_CYCLES(UNIT)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .cond_first(cond_first), .cond_second(cond_second),
    .thermal_throttle_line_n(throttle_n), .multi_pin_in(multi_n),
    .second_duty_output(second_duty_output), .fan_running(fan_running),
    .fan_full_duty(fan_full_duty), .duty_pin_out(duty_pin_out),
    .duty_pin_oe(duty_pin_oe), .multi_pin_out(multi_pin_out),
    .multi_pin_oe(multi_pin_oe), .alert_n(alert_n));
  amtt_hot_source src_a (.hot_req(hot_a), .line_n(throttle_n));
  amtt_hot_source src_b (.hot_req(hot_b), .line_n(multi_n));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic results;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
    end
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // A clock passes after each access so that back-to-back strobes never toggle in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    check(reg_rdata, exp, "register read");
    cyc(1);
  endtask

  task automatic rdx(input logic [7:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
  endtask

  // Holds one throttle line low for n cycles, then lets the syncs settle.
  task automatic hot(input bit on_multi, input int n);
    if (on_multi) hot_b = 1'b1;
    else hot_a = 1'b1;
    cyc(n);
    hot_a = 1'b0;
    hot_b = 1'b0;
    cyc(6);
  endtask

  // Pulse lengths are chosen off the unit boundary so sync skew cannot change the count.
  function automatic logic [7:0] units(input int n);
    return (n / UNIT < 1) ? 8'h01 : ((n / UNIT > 255) ? 8'hFF : 8'(n / UNIT));
  endfunction

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] r;
    logic [7:0] m1;
    logic [7:0] m2;
    logic [2:0] b;
    logic       masked;
    {reg_wr, reg_rd, reg_addr, reg_wdata, cond_first, cond_second} = '0;
    {hot_a, hot_b, second_duty_output, fan_running} = '0;
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    for (int k = 0; k < 6; k++) rdchk(RST_ADDRS[47 - 8 * k -: 8], 8'h00);
    wr(ADDR_TIMER, 8'h55);
    rdchk(ADDR_TIMER, 8'h00);
    cond_first[6] = 1'b1;
    cyc(3);
    check(multi_pin_oe, 8'h00, "pin idle after reset");
    for (int f = 0; f < 8; f++) begin
      second_duty_output = 1'($random(seed));
      wr(ADDR_CONFIG_FOUR, {6'h00, f[1:0]});
      wr(ADDR_CONFIG_THREE, {7'h00, f[2]});
      cyc(2);
      check(multi_pin_oe, {7'h00, f[1:0] == 2'b10}, "multi pin enable");
      check(multi_pin_out, 8'h00, "multi pin level");
      check(duty_pin_oe, 8'h01, "duty pin enable");
      check(duty_pin_out, f[2] ? 8'h00 : {7'h00, second_duty_output}, "duty pin");
    end
    {cond_first, cond_second} = '0;
    wr(ADDR_CONFIG_THREE, 8'h00);
    wr(ADDR_CONFIG_FOUR, 8'h00);
    rdx(ADDR_STATUS_FIRST);
    for (int i = 0; i < 40; i++) begin
      r = 8'($random(seed));
      m1 = (i == 0) ? 8'h80 : ((i == 1) ? 8'h00 : 8'($random(seed)));
      m2 = (i < 2) ? 8'h00 : 8'($random(seed));
      if (i < 2) r[3] = 1'b1;
      b = r[3] ? r[2:0] : r[2:0] % 3'd7;
      wr(ADDR_MASK_FIRST, m1);
      wr(ADDR_MASK_SECOND, m2);
      rdchk(ADDR_MASK_FIRST, m1);
      masked = r[3] ? (m1[7] | m2[b]) : m1[b];
      if (r[3]) cond_second[b] = 1'b1;
      else cond_first[b] = 1'b1;
      cyc(3);
      check(alert_n, {7'h00, masked}, "alert level");
      if (r[3]) rdchk(ADDR_STATUS_FIRST, 8'h80);
      r[4] = r[3];
      r[7:0] = r[4] ? ADDR_STATUS_SECOND : ADDR_STATUS_FIRST;
      rdchk(r, 8'h01 << b);
      {cond_first, cond_second} = '0;
      cyc(2);
      check(alert_n, {7'h00, masked}, "alert held");
      rdchk(r, 8'h01 << b);
      rdchk(r, 8'h00);
      cyc(2);
      check(alert_n, 8'h01, "alert released");
    end
    wr(ADDR_MASK_FIRST, 8'h00);
    wr(ADDR_MASK_SECOND, 8'h00);
    wr(ADDR_CONFIG_THREE, 8'h02);
    hot(0, 4);
    rdchk(ADDR_TIMER, 8'h01);
    hot(0, 20);
    rdchk(ADDR_TIMER, units(20));
    rdchk(ADDR_TIMER, 8'h00);
    hot(0, 20);
    hot(0, 28);
    rdchk(ADDR_TIMER, units(48));
    hot(0, 2100);
    rdchk(ADDR_TIMER, 8'hFF);
    wr(ADDR_CONFIG_THREE, 8'h00);
    hot(0, 20);
    wr(ADDR_CONFIG_FOUR, 8'h01);
    hot(1, 20);
    rdchk(ADDR_TIMER, 8'h00);
    wr(ADDR_CONFIG_THREE, 8'h02);
    hot_a = 1'b1;
    cyc(20);
    rdx(ADDR_TIMER);
    rdchk(ADDR_TIMER, 8'h01);
    hot_a = 1'b0;
    cyc(6);
    rdx(ADDR_TIMER);
    rdx(ADDR_STATUS_SECOND);
    rdx(ADDR_STATUS_FIRST);
    wr(ADDR_MASK_FIRST, 8'h01);
    hot_b = 1'b1;
    cyc(20);
    rdx(ADDR_TIMER);
    cyc(3);
    check(alert_n, 8'h00, "alert on throttle");
    hot_b = 1'b0;
    cyc(6);
    rdchk(ADDR_STATUS_SECOND, 8'h20);
    wr(ADDR_MASK_SECOND, 8'h20);
    cyc(2);
    check(alert_n, 8'h01, "throttle alert masked");
    rdx(ADDR_TIMER);
    rdx(ADDR_STATUS_SECOND);
    rdx(ADDR_STATUS_FIRST);
    wr(ADDR_CONFIG_FOUR, 8'h00);
    for (int k = 0; k < 6; k++) begin
      fan_running = 4'($random(seed));
      wr(ADDR_CONFIG_THREE, (k < 4) ? 8'h06 : ((k == 4) ? 8'h02 : 8'h04));
      hot_a = 1'b1;
      cyc(5);
      check(fan_full_duty, (k < 4) ? {4'h0, fan_running} : 8'h00, "full_speed_on_throttle");
      hot_a = 1'b0;
      cyc(5);
      check(fan_full_duty, 8'h00, "full_speed_on_throttle ends");
    end
    results();
  end
endmodule
`default_nettype wire
